// *** rtl/alc_pkg.sv ***
package alc_pkg;
    // geometry
    localparam int unsigned ALC_NUM_COMP   = 6;
    localparam int unsigned ALC_DATA_W     = 12;
    // register byte addresses (low bits decoded)
    localparam logic [31:0] ALC_ENABLE_OFS = 32'h0014008c;
    localparam logic [31:0] ALC_RESULT_OFS = 32'h00140090;
    // enable register field positions
    localparam int unsigned ALC_ON_POS     = 0;
    localparam int unsigned ALC_PICK_POS   = 8;
    localparam int unsigned ALC_IRQ_POS    = 16;
    // result register field positions
    localparam int unsigned ALC_STICKY_POS = 0;
    localparam int unsigned ALC_LIVE_POS   = 16;
    // reset values
    localparam logic [5:0]  ALC_ON_RST     = 6'h00;
    localparam logic [5:0]  ALC_PICK_RST   = 6'h00;
    localparam logic [11:0] ALC_IRQ_RST    = 12'h000;
    localparam logic [11:0] ALC_STICKY_RST = 12'h000;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } alc_apb_req_t;

    // apb answer bundle
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } alc_apb_rsp_t;

    // all block state
    typedef struct packed {
        logic [5:0]  comparator_on;
        logic [5:0]  source_pick;
        logic [11:0] irq_on;
        logic [11:0] sticky;
        logic        irq_flag;
        logic [31:0] prdata;
        logic        pslverr;
    } alc_state_t;
endpackage : alc_pkg

// *** rtl/alc_limit_comparators.sv ***
// Behaviour
// - six comparators, each enabled by enable register bits 0 to 5
// - after reset all enable, select and interrupt enable bits are zero
// - select bit 8+n picks raw (0) or averaged (1) result n
// - comparator n always watches result slot n only
// - upper interrupt enable at bit 17+2n gates upper sticky status
// - lower interrupt enable at bit 16+2n gates lower sticky status
// - live status bits 16 to 27 show current limit hits, upper odd
// - sticky status bits 0 to 11 latch hits and clear on read
// - upper limit hit when input is equal to or above upper limit
// - lower limit hit when input is equal to or below lower limit
// - any limit hit sets the shared compare interrupt flag
`timescale 1ns/10ps
`default_nettype none
module alc_limit_comparators
    import alc_pkg::*;
#(
    parameter int unsigned N_COMP = ALC_NUM_COMP,
    parameter int unsigned DW     = ALC_DATA_W
) (
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // apb slave
    input  wire alc_apb_req_t          apb_req_i,
    output var alc_apb_rsp_t           apb_rsp_o,
    // converter results and limits, slot n in slice n
    input  wire logic [N_COMP*DW-1:0]  raw_result_i,
    input  wire logic [N_COMP*DW-1:0]  avg_result_i,
    input  wire logic [N_COMP*DW-1:0]  upper_limit_i,
    input  wire logic [N_COMP*DW-1:0]  lower_limit_i,
    // shared compare flag handling and live status
    input  wire logic                  irq_flag_clear_i,
    output logic                       irq_flag_o,
    output logic [2*N_COMP-1:0]        live_o
);

    alc_state_t              st;
    alc_state_t              next_st;
    logic [2*N_COMP-1:0]     live;
    logic                    rd_acc;
    logic                    wr_acc;
    logic                    hit_en;
    logic                    hit_res;

    // per-slot comparison, slot n only feeds comparator n
    for (genvar n = 0; n < N_COMP; n++) begin : g_cmp
        logic [DW-1:0] sample;
        logic [DW-1:0] up_lim;
        logic [DW-1:0] lo_lim;
        assign up_lim = upper_limit_i[n*DW +: DW];
        assign lo_lim = lower_limit_i[n*DW +: DW];
        // raw or averaged pick
        assign sample = st.source_pick[n] ? avg_result_i[n*DW +: DW]
                                          : raw_result_i[n*DW +: DW];
        // upper at odd, lower at even position
        assign live[2*n+1] = st.comparator_on[n] && (sample >= up_lim);
        assign live[2*n]   = st.comparator_on[n] && (sample <= lo_lim);
    end

    // apb decode on the low address bits, zero wait states
    assign hit_en  = apb_req_i.paddr[11:0] == ALC_ENABLE_OFS[11:0];
    assign hit_res = apb_req_i.paddr[11:0] == ALC_RESULT_OFS[11:0];
    assign rd_acc  = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;
    assign wr_acc  = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;

    // next state
    always_comb begin
        next_st = st;
        // sticky bits: set wins over the read clear
        if (rd_acc && hit_res) begin
            next_st.sticky = '0;
        end
        next_st.sticky = next_st.sticky | (live & st.irq_on);
        // shared flag, set wins over clear
        if (irq_flag_clear_i) begin
            next_st.irq_flag = 1'b0;
        end
        if (|live) begin
            next_st.irq_flag = 1'b1;
        end
        // writes, reserved bits dropped
        if (wr_acc && hit_en) begin
            next_st.comparator_on = apb_req_i.pwdata[ALC_ON_POS +: 6];
            next_st.source_pick   = apb_req_i.pwdata[ALC_PICK_POS +: 6];
            next_st.irq_on        = apb_req_i.pwdata[ALC_IRQ_POS +: 12];
        end
        // read data captured in setup, presented in access
        if (rd_acc) begin
            next_st.prdata  = '0;
            next_st.pslverr = !(hit_en || hit_res);
            if (hit_en) begin
                next_st.prdata[ALC_ON_POS +: 6]   = st.comparator_on;
                next_st.prdata[ALC_PICK_POS +: 6] = st.source_pick;
                next_st.prdata[ALC_IRQ_POS +: 12] = st.irq_on;
            end else if (hit_res) begin
                next_st.prdata[ALC_LIVE_POS +: 12]   = live;
                next_st.prdata[ALC_STICKY_POS +: 12] = st.sticky | (live & st.irq_on);
            end
        end else if (apb_req_i.psel && !apb_req_i.penable) begin
            next_st.prdata  = '0;
            next_st.pslverr = !(hit_en || hit_res);
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st.comparator_on <= ALC_ON_RST;
            st.source_pick   <= ALC_PICK_RST;
            st.irq_on        <= ALC_IRQ_RST;
            st.sticky        <= ALC_STICKY_RST;
            st.irq_flag      <= 1'b0;
            st.prdata        <= 32'h0000_0000;
            st.pslverr       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    // one driver for the whole answer bundle, error only in the access phase
    assign apb_rsp_o  = '{pready:  1'b1,
                          pslverr: st.pslverr && apb_req_i.psel && apb_req_i.penable,
                          prdata:  st.prdata};
    assign irq_flag_o = st.irq_flag;
    assign live_o            = live;

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_res_read;
        apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite && hit_res;
    endsequence

    AST_ENABLE_OFF_NO_LIVE: assert property (
        !st.comparator_on[0] |-> !live[0] && !live[1])
        else $error("disabled comparator shows live hit");
    AST_STICKY_NEEDS_CAUSE: assert property (
        $rose(st.sticky[0]) |-> $past(live[0] && st.irq_on[0]))
        else $error("sticky bit set without enabled hit");
    AST_NO_IRQ_NO_STICKY: assert property (
        !st.irq_on[0] && !$past(st.irq_on[0]) && $past(rd_acc && hit_res) |-> !st.sticky[0])
        else $error("lower sticky set while its enable is off");
    AST_READ_CLEARS: assert property (
        s_res_read ##0 !(|(live & st.irq_on)) |=> st.sticky == 12'h000)
        else $error("result read did not clear sticky bits");
    AST_STICKY_HOLDS: assert property (
        st.sticky[1] && !(rd_acc && hit_res) |=> st.sticky[1])
        else $error("sticky bit lost without read");
    AST_FLAG_ON_HIT: assert property (
        |live |=> irq_flag_o)
        else $error("limit hit did not raise shared flag");
    AST_UPPER_EDGE: assert property (
        st.comparator_on[0] && !st.source_pick[0]
        && raw_result_i[DW-1:0] == upper_limit_i[DW-1:0] |-> live[1])
        else $error("equal upper limit not flagged");
    AST_LOWER_EDGE: assert property (
        st.comparator_on[0] && st.source_pick[0]
        && avg_result_i[DW-1:0] == lower_limit_i[DW-1:0] |-> live[0])
        else $error("equal lower limit not flagged on averaged input");
    AST_RSV_ZERO: assert property (
        s_res_read |=> apb_rsp_o.prdata[15:12] == 4'h0 && apb_rsp_o.prdata[31:28] == 4'h0)
        else $error("reserved result bits not zero");
    AST_WRITE_TAKES: assert property (
        wr_acc && hit_en |=> st.comparator_on == $past(apb_req_i.pwdata[5:0]))
        else $error("enable write not stored");

    // bus phases used by the checks below
    sequence s_en_read;
        apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite && hit_en;
    endsequence

    sequence s_stray_setup;
        apb_req_i.psel && !apb_req_i.penable && !(hit_en || hit_res);
    endsequence

    sequence s_access;
        apb_req_i.psel && apb_req_i.penable;
    endsequence

    // reset values, checked on the edge after each reset cycle
    AST_RESET_VALUES: assert property (
        disable iff (1'b0)
        rst_i ##1 1'b1 |-> st.comparator_on == ALC_ON_RST
        && st.source_pick == ALC_PICK_RST && st.irq_on == ALC_IRQ_RST)
        else $error("control fields not zero after reset");

    // shared flag: clear, hold, and set beating clear
    AST_FLAG_CLEARS: assert property (
        irq_flag_clear_i && !(|live) |=> !irq_flag_o)
        else $error("shared flag not cleared");
    AST_FLAG_HOLDS: assert property (
        irq_flag_o && !irq_flag_clear_i |=> irq_flag_o)
        else $error("shared flag lost without clear");
    AST_FLAG_SET_WINS: assert property (
        irq_flag_clear_i && (|live) |=> irq_flag_o)
        else $error("clear beat a limit hit on shared flag");

    // result register read data
    AST_RESULT_LIVE: assert property (
        s_res_read |=> apb_rsp_o.prdata[27:16] == $past(live))
        else $error("result read lost live status");
    AST_RESULT_STICKY: assert property (
        s_res_read ##0 st.sticky[1] |=> apb_rsp_o.prdata[1])
        else $error("result read lost sticky bit");
    AST_SET_BEATS_CLEAR: assert property (
        s_res_read ##0 live[1] && st.irq_on[1] |=> st.sticky[1])
        else $error("hit during read clear was dropped");

    // enable register read data and writes
    AST_ENABLE_RSV_ZERO: assert property (
        s_en_read |=> apb_rsp_o.prdata[7:6] == 2'h0
        && apb_rsp_o.prdata[15:14] == 2'h0 && apb_rsp_o.prdata[31:28] == 4'h0)
        else $error("reserved enable bits not zero");
    AST_ENABLE_READBACK: assert property (
        s_en_read |=> apb_rsp_o.prdata[5:0] == $past(st.comparator_on))
        else $error("enable bits not read back");
    AST_WRITE_PICK: assert property (
        wr_acc && hit_en |=> st.source_pick == $past(apb_req_i.pwdata[13:8]))
        else $error("select write not stored");
    AST_WRITE_IRQ: assert property (
        wr_acc && hit_en |=> st.irq_on == $past(apb_req_i.pwdata[27:16]))
        else $error("interrupt enable write not stored");

    // unmapped addresses answer with an error and change nothing
    AST_STRAY_ERROR: assert property (
        s_stray_setup ##1 s_access |-> apb_rsp_o.pslverr)
        else $error("unmapped access without error");
    AST_STRAY_NO_WRITE: assert property (
        wr_acc && !hit_en |=> st.comparator_on == $past(st.comparator_on))
        else $error("enable bits changed by foreign write");

    // per comparator checks, slot k against limit k
    for (genvar k = 0; k < N_COMP; k++) begin : g_chk
        logic [DW-1:0] raw_k;
        logic [DW-1:0] avg_k;
        logic [DW-1:0] up_k;
        logic [DW-1:0] lo_k;
        assign raw_k = raw_result_i[k*DW +: DW];
        assign avg_k = avg_result_i[k*DW +: DW];
        assign up_k  = upper_limit_i[k*DW +: DW];
        assign lo_k  = lower_limit_i[k*DW +: DW];

        // disabled comparator stays quiet
        AST_OFF_QUIET: assert property (
            !st.comparator_on[k] |-> !live[2*k+1] && !live[2*k])
            else $error("disabled comparator shows live hit");

        // raw input picked
        AST_RAW_UP_HIT: assert property (
            st.comparator_on[k] && !st.source_pick[k] && raw_k >= up_k
            |-> live[2*k+1])
            else $error("raw upper hit missing");
        AST_RAW_UP_CLEAR: assert property (
            st.comparator_on[k] && !st.source_pick[k] && raw_k < up_k
            |-> !live[2*k+1])
            else $error("raw upper hit below limit");
        AST_RAW_LO_HIT: assert property (
            st.comparator_on[k] && !st.source_pick[k] && raw_k <= lo_k
            |-> live[2*k])
            else $error("raw lower hit missing");
        AST_RAW_LO_CLEAR: assert property (
            st.comparator_on[k] && !st.source_pick[k] && raw_k > lo_k
            |-> !live[2*k])
            else $error("raw lower hit above limit");

        // averaged input picked
        AST_AVG_UP_HIT: assert property (
            st.comparator_on[k] && st.source_pick[k] && avg_k >= up_k
            |-> live[2*k+1])
            else $error("averaged upper hit missing");
        AST_AVG_UP_CLEAR: assert property (
            st.comparator_on[k] && st.source_pick[k] && avg_k < up_k
            |-> !live[2*k+1])
            else $error("averaged upper hit below limit");
        AST_AVG_LO_HIT: assert property (
            st.comparator_on[k] && st.source_pick[k] && avg_k <= lo_k
            |-> live[2*k])
            else $error("averaged lower hit missing");
        AST_AVG_LO_CLEAR: assert property (
            st.comparator_on[k] && st.source_pick[k] && avg_k > lo_k
            |-> !live[2*k])
            else $error("averaged lower hit above limit");

        // sticky bits rise only from an enabled hit
        AST_UP_STICKY_CAUSE: assert property (
            $rose(st.sticky[2*k+1]) |-> $past(live[2*k+1] && st.irq_on[2*k+1]))
            else $error("upper sticky set without enabled hit");
        AST_LO_STICKY_CAUSE: assert property (
            $rose(st.sticky[2*k]) |-> $past(live[2*k] && st.irq_on[2*k]))
            else $error("lower sticky set without enabled hit");

        // an enabled hit always latches
        AST_UP_STICKY_SET: assert property (
            live[2*k+1] && st.irq_on[2*k+1] |=> st.sticky[2*k+1])
            else $error("enabled upper hit not latched");
        AST_LO_STICKY_SET: assert property (
            live[2*k] && st.irq_on[2*k] |=> st.sticky[2*k])
            else $error("enabled lower hit not latched");

        // latched bits wait for a result read
        AST_UP_STICKY_HOLD: assert property (
            st.sticky[2*k+1] && !(rd_acc && hit_res) |=> st.sticky[2*k+1])
            else $error("upper sticky lost without read");
        AST_LO_STICKY_HOLD: assert property (
            st.sticky[2*k] && !(rd_acc && hit_res) |=> st.sticky[2*k])
            else $error("lower sticky lost without read");
    end

endmodule : alc_limit_comparators
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import alc_pkg::*;
    // drive, observe and bookkeeping
    logic         clk_sys_i = 1'b0;
    logic         rst_i     = 1'b1;
    alc_apb_req_t req       = '0;
    alc_apb_rsp_t rsp;
    logic [71:0]  raw       = '0;
    logic [71:0]  avg       = '0;
    logic         clr       = 1'b0;
    logic         flag;
    logic [11:0]  live;
    logic [31:0]  rd;
    logic         slverr;
    int           err_count = 0;
    int           tests_run = 0;
    int           cyc       = 0;
    // slot 0 equal upper, slot 1 equal lower, slots 2-3 just inside, 4 above, 5 below
    localparam logic [71:0] HITS = {12'h000, 12'hfff, 12'h101, 12'h7ff, 12'h100, 12'h800};
    localparam logic [71:0] CALM = {6{12'h400}};

    alc_limit_comparators u_alc_limit_comparators (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .raw_result_i(raw), .avg_result_i(avg), .upper_limit_i({6{12'h800}}),
        .lower_limit_i({6{12'h100}}), .irq_flag_clear_i(clr), .irq_flag_o(flag),
        .live_o(live));

    // clock and hang guard
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer, request held until pready seen high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        req.psel    <= 1'b1;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
        rd          = rsp.prdata;
        slverr      = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb

    task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rdchk

    // reset state, then raw source hits with interrupts off
    task automatic raw_source;
        rdchk("enable", ALC_ENABLE_OFS, 32'h0);
        rdchk("result", ALC_RESULT_OFS, 32'h0);
        raw <= HITS;
        avg <= CALM;
        apb(1'b1, ALC_ENABLE_OFS, 32'h0000003f);
        chk("live", 32'h606, {20'h0, live});
        rdchk("result", ALC_RESULT_OFS, 32'h06060000);
    endtask : raw_source

    // all ones write, reserved bits, averaged source
    task automatic reg_access;
        apb(1'b1, ALC_ENABLE_OFS, 32'hffffffff);
        rdchk("enable", ALC_ENABLE_OFS, 32'h0fff3f3f);
        rdchk("result", ALC_RESULT_OFS, 32'h0);
        avg <= HITS;
        raw <= CALM;
        repeat (2) @(posedge clk_sys_i);
        chk("live", 32'h606, {20'h0, live});
    endtask : reg_access

    // sticky latch, clear on read, shared flag
    task automatic sticky;
        avg <= CALM;
        raw <= HITS;
        apb(1'b1, ALC_ENABLE_OFS, 32'h0fff003f);
        raw <= CALM;
        @(posedge clk_sys_i);
        rdchk("result", ALC_RESULT_OFS, 32'h00000606);
        chk("flag", 32'h1, {31'h0, flag});
        rdchk("result", ALC_RESULT_OFS, 32'h0);
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
        @(posedge clk_sys_i);
        chk("flag", 32'h0, {31'h0, flag});
    endtask : sticky

    // comparator 0 off, lower enables only, unmapped access
    task automatic gating;
        apb(1'b1, ALC_ENABLE_OFS, 32'h0555003e);
        raw <= HITS;
        repeat (2) @(posedge clk_sys_i);
        chk("live", 32'h604, {20'h0, live});
        rdchk("result", ALC_RESULT_OFS, 32'h06040404);
        rdchk("unmapped", 32'h00140094, 32'h0);
        chk("pslverr", 32'h1, {31'h0, slverr});
    endtask : gating

    // reset in mid run returns every field to zero
    task automatic mid_reset;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("flag", 32'h0, {31'h0, flag});
        chk("live", 32'h0, {20'h0, live});
        rdchk("enable", ALC_ENABLE_OFS, 32'h0);
        rdchk("result", ALC_RESULT_OFS, 32'h0);
    endtask : mid_reset

    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        raw_source();
        reg_access();
        sticky();
        gating();
        mid_reset();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
